// ==== verilog/video_defines.svh ====
// Constants for the planar display buffer access block
// What this block does
// - 640x200 two-colour: B8000, plane 0, MSB leftmost
// - Two-colour pixel: 0 black, 1 intensified white
// - 640x350 mono: plane 0 video, plane 2 intensity
// - Mono pixels: black, white, blinking, intensified
// - Planar modes: eight pixels per byte, MSB first
// - 640x480 two-colour: A0000, plane 0 only
// - Sixteen colours: four planes index internal palette
// - Writes reach selected planes enabled in mask
// - 256-colour: linear 64000 bytes from A0000
// - 256-colour: each plane byte is one pixel, four per fetch
// - Lookup table: 256 entries, 18-bit colours
// - Four 64KB planes share one window
// - Windows: A0000 64KB, B0000 32KB, B8000 32KB
// - Read mode 0 returns selected plane byte
// - Read mode 1 returns colour compare result
// - All registers read back except LUT read index, toggle
// - Register group port addresses are fixed except CRT group
// - 200-line modes scan each row twice
// - I/O select bit moves CRT ports 3Bx/3Dx
`ifndef VIDEO_DEFINES_SVH
`define VIDEO_DEFINES_SVH
`define PORT_ATTR_WR   16'h03c0
`define PORT_ATTR_RD   16'h03c1
`define PORT_MISC_WR   16'h03c2
`define PORT_SEQ_IDX   16'h03c4
`define PORT_SEQ_DAT   16'h03c5
`define PORT_LUT_MASK  16'h03c6
`define PORT_LUT_RIDX  16'h03c7
`define PORT_LUT_WIDX  16'h03c8
`define PORT_LUT_DATA  16'h03c9
`define PORT_MISC_RD   16'h03cc
`define PORT_GFX_IDX   16'h03ce
`define PORT_GFX_DAT   16'h03cf
`define PORT_CRT_MONO  12'h03b
`define PORT_CRT_COLR  12'h03d
`define CRT_IDX_LO     4'h4
`define CRT_DAT_LO     4'h5
`define CRT_STAT_LO    4'ha
`define WIN_A0000      20'ha0000
`define WIN_B0000      20'hb0000
`define WIN_B8000      20'hb8000
`define WIN_64K        20'h10000
`define WIN_32K        20'h08000
`define SEQ_MAP_MASK   3'h2
`define SEQ_MEM_MODE   3'h4
`define GFX_CMP        4'h2
`define GFX_RMAP       4'h4
`define GFX_MODE       4'h5
`define GFX_MISC       4'h6
`define GFX_CARE       4'h7
`define ATR_MODE       5'h10
`define ATR_PLANE_EN   5'h12
`define CRT_MAXSCAN    5'h09
`define MISC_IOS       0
`define MISC_ERAM      1
`define MEMMODE_CHAIN4 3
`define GMODE_READ1    3
`define GMODE_256      6
`define GMISC_MAP      3:2
`define ATR_MONO       1
`define CRT_DOUBLE     7
`define STAT_VR        3
`define STAT_DISP      0
`define CODE_BLACK     8'h00
`define CODE_WHITE     8'h07
`define CODE_BRIGHT    8'h0f
`define TWO_PLANE_EN   4'h1
`define BLINK_BIT      4
`define LUT_MASK_RST   8'hff
`define PIX_PER_BYTE   4'h8
`define PIX_PER_FETCH  4'h4
`define LUT_R          17:12
`define LUT_G          11:6
`define LUT_B          5:0
`endif

// ==== verilog/video_pkg.sv ====
// Types for the planar display buffer access block
package video_pkg;
	typedef enum logic [3:0] {
		DM_TWO     = 4'b0001,
		DM_MONO    = 4'b0010,
		DM_SIXTEEN = 4'b0100,
		DM_256     = 4'b1000
	} disp_mode_t;

	typedef struct packed {
		logic [2:0]       seq_idx;
		logic [7:0][7:0]  seq;
		logic [3:0]       gfx_idx;
		logic [15:0][7:0] gfx;
		logic [4:0]       crt_idx;
		logic [31:0][7:0] crt;
		logic [4:0]       atr_idx;
		logic             atr_flip;
		logic [31:0][7:0] atr;
		logic [7:0]       misc;
		logic [7:0]       lut_mask;
		logic [7:0]       io_rdata;
		logic             io_oe;
		logic             rd_pend;
		logic [1:0]       rd_plane;
		logic             rd_cmp;
		logic [7:0]       mem_rdata;
		logic             mem_oe;
		logic             fetch_pend;
		logic [3:0][7:0]  shift;
		logic [3:0]       shift_cnt;
		logic [7:0]       code;
		logic             code_valid;
		logic [9:0]       row;
		logic             vr_prev;
		logic [4:0]       blink_cnt;
	} access_state_t;

	typedef struct packed {
		logic [7:0]  widx;
		logic [7:0]  ridx;
		logic [1:0]  wsub;
		logic [1:0]  rsub;
		logic [11:0] wbuf;
		logic        rgb_valid;
		logic [17:0] rgb;
	} lut_state_t;
endpackage : video_pkg

// ==== verilog/plane_store.sv ====
// One 64KB display plane with a system port and a scan-out read port
`timescale 1ns/1ps
`default_nettype none
module plane_store #(
	parameter int AW = 16
) (
	// Clock
	input  wire logic          ref_clk,
	// System side
	input  wire logic [AW-1:0] sys_addr,
	input  wire logic          sys_we,
	input  wire logic [7:0]    sys_wdata,
	output logic      [7:0]    sys_rdata,
	// Scan-out side
	input  wire logic [AW-1:0] vid_addr,
	output logic      [7:0]    vid_rdata
);
	logic [7:0] mem [0:(1<<AW)-1];

	// Read before write: a same-cycle read returns the old byte
	always_ff @(posedge ref_clk) begin
		if (sys_we) begin
			mem[sys_addr] <= sys_wdata;
		end
		sys_rdata <= mem[sys_addr];
		vid_rdata <= mem[vid_addr];
	end
endmodule : plane_store
`default_nettype wire

// ==== verilog/colour_lut.sv ====
// External colour lookup table with three-byte index/data sequencing
`timescale 1ns/1ps
`default_nettype none
`include "video_defines.svh"
module colour_lut #(
	parameter int ENTRIES = 256
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	// Register access
	input  wire logic        widx_ld,
	input  wire logic        ridx_ld,
	input  wire logic        dat_wr,
	input  wire logic        dat_rd,
	input  wire logic [7:0]  wdata,
	output logic      [7:0]  rdata,
	output logic      [7:0]  widx,
	// Pixel lookup
	input  wire logic [7:0]  vid_code,
	input  wire logic        vid_valid,
	output logic      [17:0] rgb,
	output logic             rgb_valid
);
	logic [17:0] table_mem [0:ENTRIES-1];
	video_pkg::lut_state_t cur;
	video_pkg::lut_state_t next;
	logic [17:0] rd_entry;
	logic        commit;

	assign rd_entry  = table_mem[cur.ridx];
	assign commit    = dat_wr && (cur.wsub == 2'h2);
	assign widx      = cur.widx;
	assign rgb       = cur.rgb;
	assign rgb_valid = cur.rgb_valid;

	always_comb begin
		unique case (cur.rsub)
			2'h0:    rdata = {2'b00, rd_entry[`LUT_R]};
			2'h1:    rdata = {2'b00, rd_entry[`LUT_G]};
			default: rdata = {2'b00, rd_entry[`LUT_B]};
		endcase
	end

	always_comb begin
		next = cur;
		if (widx_ld) begin
			next.widx = wdata;
			next.wsub = 2'h0;
		end else if (dat_wr) begin
			if (cur.wsub == 2'h0) begin
				next.wbuf[11:6] = wdata[5:0];
				next.wsub       = 2'h1;
			end else if (cur.wsub == 2'h1) begin
				next.wbuf[5:0] = wdata[5:0];
				next.wsub      = 2'h2;
			end else begin
				next.wsub = 2'h0;
				next.widx = 8'(cur.widx + 8'h01);
			end
		end
		if (ridx_ld) begin
			next.ridx = wdata;
			next.rsub = 2'h0;
		end else if (dat_rd) begin
			if (cur.rsub == 2'h2) begin
				next.rsub = 2'h0;
				next.ridx = 8'(cur.ridx + 8'h01);
			end else begin
				next.rsub = 2'(cur.rsub + 2'h1);
			end
		end
		next.rgb       = table_mem[vid_code];
		next.rgb_valid = vid_valid;
	end

	// Table contents are not reset; software loads them before display
	always_ff @(posedge ref_clk) begin
		if (commit) begin
			table_mem[cur.widx] <= {cur.wbuf, wdata[5:0]};
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cur <= '0;
		end else begin
			cur <= next;
		end
	end
endmodule : colour_lut
`default_nettype wire

// ==== verilog/planar_video_buffer_access.sv ====
// Planar display buffer access: window decode, plane writes, reads, registers, pixels
`timescale 1ns/1ps
`default_nettype none
`include "video_defines.svh"
module planar_video_buffer_access #(
	parameter int PLANE_AW = 16
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	// System memory cycles
	input  wire logic [19:0] mem_addr,
	input  wire logic        mem_rd,
	input  wire logic        mem_wr,
	input  wire logic [7:0]  mem_wdata,
	output logic      [7:0]  mem_rdata,
	output logic             mem_rdata_oe,
	// System I/O cycles
	input  wire logic [15:0] io_addr,
	input  wire logic        io_rd,
	input  wire logic        io_wr,
	input  wire logic [7:0]  io_wdata,
	output logic      [7:0]  io_rdata,
	output logic             io_rdata_oe,
	// Display timing
	input  wire logic        scan_req,
	input  wire logic [15:0] scan_addr,
	input  wire logic [9:0]  scan_line,
	input  wire logic        vert_retrace,
	input  wire logic        disp_inactive,
	// Display output
	output logic      [9:0]  scan_row,
	output logic      [17:0] pix_rgb,
	output logic             pix_valid
);
	video_pkg::access_state_t cur;
	video_pkg::access_state_t next;
	video_pkg::disp_mode_t    mode;

	// Window decode
	logic [19:0]         win_base;
	logic [19:0]         win_size;
	logic [19:0]         mem_off;
	logic                mem_hit;
	logic                chain4;

	// Plane access
	logic [3:0]          plane_sel;
	logic [3:0]          plane_we;
	logic [PLANE_AW-1:0] plane_addr;
	logic [3:0][7:0]     plane_rd;
	logic [3:0][7:0]     plane_vid;
	logic [7:0]          cmp_result;

	// Register ports
	logic                io_hit;
	logic [7:0]          io_val;
	logic                ios;

	// Pixel path
	logic [3:0]          pbits;
	logic [3:0]          pal_idx;
	logic [7:0]          pix_code;
	logic [7:0]          lut_rdata;
	logic [7:0]          lut_widx;

	// CRT group ports follow the I/O select bit
	function automatic logic crt_port(input logic [15:0] a, input logic sel, input logic [3:0] lo);
		crt_port = (a[15:4] == (sel ? `PORT_CRT_COLR : `PORT_CRT_MONO)) && (a[3:0] == lo);
	endfunction : crt_port

	assign ios    = cur.misc[`MISC_IOS];
	assign chain4 = cur.seq[`SEQ_MEM_MODE][`MEMMODE_CHAIN4];

	// Buffer window placement
	always_comb begin
		// Code 00 decodes like 01: the full 64KB window
		win_base = `WIN_A0000;
		win_size = `WIN_64K;
		unique case (cur.gfx[`GFX_MISC][`GMISC_MAP])
			2'b00, 2'b01: begin
				win_base = `WIN_A0000;
				win_size = `WIN_64K;
			end
			2'b10: begin
				win_base = `WIN_B0000;
				win_size = `WIN_32K;
			end
			2'b11: begin
				win_base = `WIN_B8000;
				win_size = `WIN_32K;
			end
		endcase
	end

	assign mem_off = 20'(mem_addr - win_base);
	// Cycles outside the window, or with RAM decode off, are left alone
	assign mem_hit = cur.misc[`MISC_ERAM] && (mem_addr >= win_base) && (mem_off < win_size);

	// Linear chained addressing picks one plane by the low address bits
	assign plane_sel  = chain4 ? (4'b0001 << mem_off[1:0]) : 4'b1111;
	assign plane_addr = chain4 ? PLANE_AW'(mem_off[15:2]) : PLANE_AW'(mem_off[15:0]);
	assign plane_we   = {4{mem_wr && mem_hit}} & plane_sel & cur.seq[`SEQ_MAP_MASK][3:0];

	genvar p;
	generate
		for (p = 0; p < 4; p++) begin : g_plane
			plane_store #(
				.AW(PLANE_AW)
			) u_plane (
				.ref_clk  (ref_clk),
				.sys_addr (plane_addr),
				.sys_we   (plane_we[p]),
				.sys_wdata(mem_wdata),
				.sys_rdata(plane_rd[p]),
				.vid_addr (PLANE_AW'(scan_addr)),
				.vid_rdata(plane_vid[p])
			);
		end
	endgenerate

	// Colour compare: a don't-care bit of 0 drops that plane from the match
	always_comb begin
		cmp_result = 8'h00;
		for (int i = 0; i < 8; i++) begin
			cmp_result[i] = &(~cur.gfx[`GFX_CARE][3:0]
				| ~({plane_rd[3][i], plane_rd[2][i], plane_rd[1][i], plane_rd[0][i]}
				^ cur.gfx[`GFX_CMP][3:0]));
		end
	end

	// Register read-back; the attribute toggle is never visible
	always_comb begin
		io_hit = 1'b1;
		io_val = 8'h00;
		if (io_addr == `PORT_SEQ_IDX) begin
			io_val = {5'h00, cur.seq_idx};
		end else if (io_addr == `PORT_SEQ_DAT) begin
			io_val = cur.seq[cur.seq_idx];
		end else if (io_addr == `PORT_GFX_IDX) begin
			io_val = {4'h0, cur.gfx_idx};
		end else if (io_addr == `PORT_GFX_DAT) begin
			io_val = cur.gfx[cur.gfx_idx];
		end else if (crt_port(io_addr, ios, `CRT_IDX_LO)) begin
			io_val = {3'h0, cur.crt_idx};
		end else if (crt_port(io_addr, ios, `CRT_DAT_LO)) begin
			io_val = cur.crt[cur.crt_idx];
		end else if (crt_port(io_addr, ios, `CRT_STAT_LO)) begin
			io_val[`STAT_VR]   = vert_retrace;
			io_val[`STAT_DISP] = disp_inactive;
		end else if (io_addr == `PORT_ATTR_WR) begin
			io_val = {3'h0, cur.atr_idx};
		end else if (io_addr == `PORT_ATTR_RD) begin
			io_val = cur.atr[cur.atr_idx];
		end else if (io_addr == `PORT_MISC_RD) begin
			io_val = cur.misc;
		end else if (io_addr == `PORT_LUT_MASK) begin
			io_val = cur.lut_mask;
		end else if (io_addr == `PORT_LUT_WIDX) begin
			io_val = lut_widx;
		end else if (io_addr == `PORT_LUT_DATA) begin
			io_val = lut_rdata;
		end else begin
			io_hit = 1'b0;
		end
	end

	// Display mode from the programmed registers
	always_comb begin
		if (cur.gfx[`GFX_MODE][`GMODE_256]) begin
			mode = video_pkg::DM_256;
		end else if (cur.atr[`ATR_MODE][`ATR_MONO]) begin
			mode = video_pkg::DM_MONO;
		end else if (cur.atr[`ATR_PLANE_EN][3:0] == `TWO_PLANE_EN) begin
			mode = video_pkg::DM_TWO;
		end else begin
			mode = video_pkg::DM_SIXTEEN;
		end
	end

	// Most significant bit of each plane byte is the next pixel out
	assign pbits   = {cur.shift[3][7], cur.shift[2][7], cur.shift[1][7], cur.shift[0][7]};
	assign pal_idx = pbits & cur.atr[`ATR_PLANE_EN][3:0];

	always_comb begin
		pix_code = `CODE_BLACK;
		unique case (mode)
			video_pkg::DM_TWO: begin
				pix_code = pbits[0] ? `CODE_BRIGHT : `CODE_BLACK;
			end
			video_pkg::DM_MONO: begin
				case ({pbits[2], pbits[0]})
					2'b00: pix_code = `CODE_BLACK;
					2'b01: pix_code = `CODE_WHITE;
					2'b10: pix_code = cur.blink_cnt[`BLINK_BIT] ? `CODE_WHITE : `CODE_BLACK;
					2'b11: pix_code = `CODE_BRIGHT;
				endcase
			end
			video_pkg::DM_SIXTEEN: begin
				pix_code = {2'b00, cur.atr[{1'b0, pal_idx}][5:0]};
			end
			video_pkg::DM_256: begin
				pix_code = cur.shift[0];
			end
		endcase
	end

	always_comb begin
		next            = cur;
		next.io_oe      = 1'b0;
		next.mem_oe     = 1'b0;
		next.rd_pend    = 1'b0;
		next.code_valid = 1'b0;
		// Register writes
		if (io_wr) begin
			if (io_addr == `PORT_SEQ_IDX) begin
				next.seq_idx = io_wdata[2:0];
			end

			if (io_addr == `PORT_SEQ_DAT) begin
				next.seq[cur.seq_idx] = io_wdata;
			end

			if (io_addr == `PORT_GFX_IDX) begin
				next.gfx_idx = io_wdata[3:0];
			end

			if (io_addr == `PORT_GFX_DAT) begin
				next.gfx[cur.gfx_idx] = io_wdata;
			end

			if (crt_port(io_addr, ios, `CRT_IDX_LO)) begin
				next.crt_idx = io_wdata[4:0];
			end

			if (crt_port(io_addr, ios, `CRT_DAT_LO)) begin
				next.crt[cur.crt_idx] = io_wdata;
			end

			// One port carries index then data, alternating on each write
			if (io_addr == `PORT_ATTR_WR) begin
				if (cur.atr_flip) begin
					next.atr[cur.atr_idx] = io_wdata;
				end else begin
					next.atr_idx = io_wdata[4:0];
				end
				next.atr_flip = ~cur.atr_flip;
			end

			if (io_addr == `PORT_MISC_WR) begin
				next.misc = io_wdata;
			end

			if (io_addr == `PORT_LUT_MASK) begin
				next.lut_mask = io_wdata;
			end
		end

		// Register reads answer one cycle later
		if (io_rd && io_hit) begin
			next.io_oe    = 1'b1;
			next.io_rdata = io_val;
		end

		// Reading status puts the attribute port back to index phase
		if (io_rd && crt_port(io_addr, ios, `CRT_STAT_LO)) begin
			next.atr_flip = 1'b0;
		end

		// Memory reads: capture the settings, answer after the plane read
		if (mem_rd && mem_hit) begin
			next.rd_pend  = 1'b1;
			next.rd_plane = chain4 ? mem_off[1:0] : cur.gfx[`GFX_RMAP][1:0];
			next.rd_cmp   = cur.gfx[`GFX_MODE][`GMODE_READ1];
		end

		if (cur.rd_pend) begin
			next.mem_oe    = 1'b1;
			next.mem_rdata = cur.rd_cmp ? cmp_result : plane_rd[cur.rd_plane];
		end

		// Scan-out: a new fetch overrides any pixels still being shifted
		next.fetch_pend = scan_req;
		if (cur.fetch_pend) begin
			next.shift     = plane_vid;
			next.shift_cnt = (mode == video_pkg::DM_256) ? `PIX_PER_FETCH : `PIX_PER_BYTE;
		end else if (cur.shift_cnt != 4'h0) begin
			next.code_valid = 1'b1;
			next.code       = pix_code & cur.lut_mask;
			next.shift_cnt  = 4'(cur.shift_cnt - 4'h1);
			if (mode == video_pkg::DM_256) begin
				next.shift = {cur.shift[0], cur.shift[3:1]};
			end else begin
				for (int k = 0; k < 4; k++) begin
					next.shift[k] = {cur.shift[k][6:0], 1'b0};
				end
			end
		end

		// Double-scanned modes fetch each stored row on two lines
		next.row = cur.crt[`CRT_MAXSCAN][`CRT_DOUBLE] ? {1'b0, scan_line[9:1]} : scan_line;

		// Blink phase steps once per retrace start
		next.vr_prev = vert_retrace;
		if (vert_retrace && !cur.vr_prev) begin
			next.blink_cnt = 5'(cur.blink_cnt + 5'h01);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cur          <= '0;
			// Mask resets open so every code reaches the table
			cur.lut_mask <= `LUT_MASK_RST;
		end else begin
			cur <= next;
		end
	end

	colour_lut #(
		.ENTRIES(256)
	) u_lut (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.widx_ld  (io_wr && (io_addr == `PORT_LUT_WIDX)),
		.ridx_ld  (io_wr && (io_addr == `PORT_LUT_RIDX)),
		.dat_wr   (io_wr && (io_addr == `PORT_LUT_DATA)),
		.dat_rd   (io_rd && (io_addr == `PORT_LUT_DATA)),
		.wdata    (io_wdata),
		.rdata    (lut_rdata),
		.widx     (lut_widx),
		.vid_code (cur.code),
		.vid_valid(cur.code_valid),
		.rgb      (pix_rgb),
		.rgb_valid(pix_valid)
	);

	// Every output below comes straight from a register
	assign mem_rdata    = cur.mem_rdata;
	assign mem_rdata_oe = cur.mem_oe;
	assign io_rdata     = cur.io_rdata;
	assign io_rdata_oe  = cur.io_oe;
	assign scan_row     = cur.row;
endmodule : planar_video_buffer_access
`default_nettype wire

// ==== testbench/planar_video_buffer_access_asserts.sv ====
// Port-level timing checks for the planar buffer access block
`timescale 1ns/1ps
`default_nettype none
module pvba_checker #(
	parameter int PLANE_AW = 16
) (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rst_b,
	// Memory cycles
	input wire logic [19:0] mem_addr,
	input wire logic        mem_rd,
	input wire logic        mem_wr,
	input wire logic        mem_rdata_oe,
	// I/O cycles
	input wire logic [15:0] io_addr,
	input wire logic        io_rd,
	input wire logic        io_wr,
	input wire logic        io_rdata_oe,
	// Pixels
	input wire logic        scan_req,
	input wire logic        pix_valid
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	// Saturates so a stale fetch can never look recent
	logic [3:0] since_req;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			since_req <= 4'hf;
		else if (scan_req)
			since_req <= 4'h1;
		else if (since_req != 4'hf)
			since_req <= since_req + 4'h1;
	end

	sequence s_io_ans;
		##1 io_rdata_oe;
	endsequence
	sequence s_pix_first;
		##4 pix_valid;
	endsequence

	property p_io_answer;
		io_rd && io_addr == 16'h03c5 |-> s_io_ans;
	endproperty
	a_io_answer: assert property (p_io_answer) else $error("sequencer read not answered");
	property p_io_refuse;
		io_rd && io_addr == 16'h03c7 |=> !io_rdata_oe;
	endproperty
	a_io_refuse: assert property (p_io_refuse) else $error("write-only port answered");
	property p_io_cause;
		io_rdata_oe |-> $past(io_rd);
	endproperty
	a_io_cause: assert property (p_io_cause) else $error("io data without read");
	property p_io_wr;
		io_wr |=> !io_rdata_oe;
	endproperty
	a_io_wr: assert property (p_io_wr) else $error("io write drove data");
	property p_mem_cause;
		mem_rdata_oe |-> $past(mem_rd, 2);
	endproperty
	a_mem_cause: assert property (p_mem_cause) else $error("mem data without read");
	property p_mem_out;
		mem_rd && (mem_addr < 20'ha0000 || mem_addr > 20'hbffff) |-> ##2 !mem_rdata_oe;
	endproperty
	a_mem_out: assert property (p_mem_out) else $error("read outside window answered");
	property p_mem_wr;
		mem_wr && !mem_rd |-> ##2 !mem_rdata_oe;
	endproperty
	a_mem_wr: assert property (p_mem_wr) else $error("mem write drove data");
	property p_mem_one;
		mem_rdata_oe && !$past(mem_rd) |=> !mem_rdata_oe;
	endproperty
	a_mem_one: assert property (p_mem_one) else $error("mem data held too long");
	property p_pix_start;
		scan_req |-> s_pix_first;
	endproperty
	a_pix_start: assert property (p_pix_start) else $error("first pixel late");
	property p_pix_win;
		pix_valid |-> since_req >= 4'h4 && since_req <= 4'hb;
	endproperty
	a_pix_win: assert property (p_pix_win) else $error("pixel outside fetch slot");
endmodule : pvba_checker

bind planar_video_buffer_access pvba_checker #(.PLANE_AW(PLANE_AW)) chk_u (
	.ref_clk(ref_clk), .rst_b(rst_b), .mem_addr(mem_addr), .mem_rd(mem_rd),
	.mem_wr(mem_wr), .mem_rdata_oe(mem_rdata_oe), .io_addr(io_addr), .io_rd(io_rd),
	.io_wr(io_wr), .io_rdata_oe(io_rdata_oe), .scan_req(scan_req), .pix_valid(pix_valid)
);
`default_nettype wire

// ==== testbench/sys_bus_model.sv ====
// System processor bus issuing memory and I/O cycles
`timescale 1ns/1ps
`default_nettype none
module sys_bus_model (
	// Clock
	input  wire logic        ref_clk,
	// I/O cycles
	output logic      [15:0] io_addr,
	output logic             io_rd,
	output logic             io_wr,
	output logic      [7:0]  io_wdata,
	input  wire logic [7:0]  io_rdata,
	// Memory cycles
	output logic      [19:0] mem_addr,
	output logic             mem_rd,
	output logic             mem_wr,
	output logic      [7:0]  mem_wdata
);
	initial begin
		{io_addr, io_rd, io_wr, io_wdata} = '0;
		{mem_addr, mem_rd, mem_wr, mem_wdata} = '0;
	end

	// One-cycle strobe; data is inverted afterwards so stale values never match
	task automatic cyc(input bit m, input bit w, input logic [19:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		if (m) begin
			mem_addr  <= a;
			mem_wdata <= d;
			mem_wr    <= w;
			mem_rd    <= !w;
		end else begin
			io_addr  <= a[15:0];
			io_wdata <= d;
			io_wr    <= w;
			io_rd    <= !w;
		end
		@(posedge ref_clk);
		{mem_rd, mem_wr, io_rd, io_wr} <= 4'h0;
		mem_wdata <= ~d;
		io_wdata  <= ~d;
	endtask : cyc

	// Reserved bits kept: read first, write back the old byte with the new bits set
	task automatic rmw(input logic [15:0] ra, input logic [15:0] wa, input logic [7:0] bits);
		logic [7:0] old;
		cyc(1'b0, 1'b0, {4'h0, ra}, 8'h00);
		@(posedge ref_clk);
		old = io_rdata;
		cyc(1'b0, 1'b1, {4'h0, wa}, old | bits);
	endtask : rmw
	// The internal palette can be rewritten by this bus through port 3c0
endmodule : sys_bus_model
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the planar buffer access block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [19:0] mem_addr;
	logic mem_rd, mem_wr, io_rd, io_wr, mem_rdata_oe, io_rdata_oe, pix_valid;
	logic [7:0] mem_wdata, mem_rdata, io_wdata, io_rdata, v, d[4];
	logic [15:0] io_addr, off;
	logic scan_req = 1'b0;
	logic [15:0] scan_addr = 16'h0;
	logic [9:0] scan_line = 10'h0;
	logic [9:0] scan_row;
	logic [17:0] pix_rgb, col_lo, col_hi;
	logic [17:0] io_q[$], mem_q[$], pix_q[$];
	logic [19:0] base, top;
	int error_cnt = 0;
	int tests_run = 0;
	int cyc_cnt = 0;

	always #2 ref_clk = ~ref_clk;

	sys_bus_model bus_u (.ref_clk(ref_clk), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
		.io_wdata(io_wdata), .io_rdata(io_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_wr(mem_wr), .mem_wdata(mem_wdata));
	planar_video_buffer_access #(.PLANE_AW(16)) dut_u (.ref_clk(ref_clk), .rst_b(rst_b),
		.mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_rdata_oe(mem_rdata_oe), .io_addr(io_addr), .io_rd(io_rd),
		.io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_oe(io_rdata_oe),
		.scan_req(scan_req), .scan_addr(scan_addr), .scan_line(scan_line),
		.vert_retrace(1'b0), .disp_inactive(1'b0), .scan_row(scan_row),
		.pix_rgb(pix_rgb), .pix_valid(pix_valid));

	task automatic check(input logic [17:0] seen, input logic [17:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// An answer nobody asked for is a mismatch as well
	task automatic take(ref logic [17:0] q[$], input logic [17:0] seen);
		if (q.size() == 0)
			check(seen, (seen === 18'h0) ? 18'h1 : 18'h0);
		else
			check(seen, q.pop_front());
	endtask : take

	always @(posedge ref_clk) begin
		if (io_rdata_oe === 1'b1) take(io_q, {10'h0, io_rdata});
		if (mem_rdata_oe === 1'b1) take(mem_q, {10'h0, mem_rdata});
		if (pix_valid === 1'b1) take(pix_q, pix_rgb);
	end

	task automatic finish_test();
		if (error_cnt == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : finish_test

	always @(posedge ref_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 6000) begin
			error_cnt++;
			finish_test();
		end
	end

	task automatic iow(input logic [15:0] a, input logic [7:0] x);
		bus_u.cyc(1'b0, 1'b1, {4'h0, a}, x);
	endtask : iow
	task automatic ior(input logic [15:0] a, input logic [7:0] e, input bit ok = 1'b1);
		if (ok) io_q.push_back({10'h0, e});
		bus_u.cyc(1'b0, 1'b0, {4'h0, a}, 8'h00);
	endtask : ior
	task automatic setr(input logic [15:0] ip, input logic [7:0] i, input logic [7:0] x);
		iow(ip, i);
		iow(ip + 16'h1, x);
	endtask : setr
	task automatic memr(input logic [19:0] a, input logic [7:0] e, input bit ok = 1'b1);
		if (ok) mem_q.push_back({10'h0, e});
		bus_u.cyc(1'b1, 1'b0, a, 8'h00);
	endtask : memr
	task automatic lut_set(input logic [7:0] i, input logic [17:0] c);
		iow(16'h03c8, i);
		for (int j = 2; j >= 0; j--) iow(16'h03c9, 8'(c >> (6 * j)) & 8'h3f);
	endtask : lut_set

	function automatic logic [7:0] cmp_res(input logic [3:0] c, input logic [3:0] k);
		cmp_res = 8'hff;
		for (int p = 0; p < 4; p++) if (k[p]) cmp_res &= ~(d[p] ^ {8{c[p]}});
	endfunction : cmp_res

	logic [15:0] rp[3] = '{16'h03c4, 16'h03ce, 16'h03b4};
	logic [7:0] ri[3] = '{8'h03, 8'h03, 8'h0c};
	logic [3:0] kc, kk;

	initial begin
		void'($urandom(64));
		repeat (12) @(posedge ref_clk);
		rst_b <= 1'b1;
		ior(16'h03c6, 8'hff);
		for (int k = 0; k < 3; k++) begin
			v = 8'($urandom);
			setr(rp[k], ri[k], v);
			ior(rp[k] + 16'h1, v);
			ior(rp[k], ri[k]);
		end
		v = 8'($urandom);
		iow(16'h03c0, 8'h05);
		iow(16'h03c0, v);
		ior(16'h03c1, v);
		ior(16'h03c7, 8'h00, 1'b0);
		io_q.push_back(18'h0);
		bus_u.rmw(16'h03cc, 16'h03c2, 8'h03);
		ior(16'h03b5, 8'h00, 1'b0);
		setr(16'h03d4, 8'h0c, ~v);
		ior(16'h03d5, ~v);
		setr(16'h03d4, 8'h09, 8'h80);
		@(posedge ref_clk) scan_line <= 10'($urandom);
		repeat (3) @(posedge ref_clk);
		#1 check({8'h0, scan_row}, {8'h0, scan_line >> 1});
		setr(16'h03d4, 8'h09, 8'h00);
		repeat (3) @(posedge ref_clk);
		#1 check({8'h0, scan_row}, {8'h0, scan_line});
		off = 16'($urandom) & 16'h7ffe;
		for (int p = 0; p < 4; p++) begin
			d[p] = 8'($urandom);
			setr(16'h03c4, 8'h02, 8'h01 << p);
			bus_u.cyc(1'b1, 1'b1, 20'ha0000 + off, d[p]);
		end
		v = 8'($urandom);
		setr(16'h03c4, 8'h02, 8'h05);
		bus_u.cyc(1'b1, 1'b1, 20'ha0000 + off, v);
		d[0] = v;
		d[2] = v;
		for (int p = 0; p < 4; p++) begin
			setr(16'h03ce, 8'h04, 8'(p));
			memr(20'ha0000 + off, d[p]);
		end
		setr(16'h03ce, 8'h05, 8'h08);
		for (int t = 0; t < 4; t++) begin
			kc = 4'($urandom);
			kk = (t == 0) ? 4'h0 : 4'($urandom);
			setr(16'h03ce, 8'h02, {4'h0, kc});
			setr(16'h03ce, 8'h07, {4'h0, kk});
			memr(20'ha0000 + off, cmp_res(kc, kk));
		end
		setr(16'h03ce, 8'h05, 8'h00);
		setr(16'h03ce, 8'h04, 8'h00);
		setr(16'h03c4, 8'h02, 8'h0f);
		for (int w = 1; w < 4; w++) begin
			base = (w == 1) ? 20'ha0000 : (w == 2) ? 20'hb0000 : 20'hb8000;
			top = base + ((w == 1) ? 20'h10000 : 20'h08000);
			v = 8'($urandom);
			setr(16'h03ce, 8'h06, 8'(w << 2));
			bus_u.cyc(1'b1, 1'b1, top - 20'h1, v);
			memr(top - 20'h1, v);
			memr(base - 20'h1, 8'h00, 1'b0);
			memr(top, 8'h00, 1'b0);
		end
		iow(16'h03c2, 8'h01);
		memr(20'hb8000, 8'h00, 1'b0);
		iow(16'h03c2, 8'h03);
		setr(16'h03ce, 8'h06, 8'h04);
		col_lo = 18'($urandom);
		col_hi = 18'($urandom);
		lut_set(8'h00, col_lo);
		ior(16'h03c8, 8'h01);
		lut_set(8'h0f, col_hi);
		iow(16'h03c0, 8'h12);
		iow(16'h03c0, 8'h01);
		v = 8'($urandom);
		bus_u.cyc(1'b1, 1'b1, 20'ha0000 + off, v);
		for (int i = 7; i >= 0; i--) pix_q.push_back(v[i] ? col_hi : col_lo);
		@(posedge ref_clk);
		scan_addr <= off;
		scan_req <= 1'b1;
		@(posedge ref_clk);
		scan_req <= 1'b0;
		repeat (14) @(posedge ref_clk);
		check(18'(io_q.size() + mem_q.size() + pix_q.size()), 18'h0);
		finish_test();
	end
endmodule : tb
`default_nettype wire
